// ### pkg/spi_pkg.sv
// register map, field positions, reset values and codes of the serial port
// assumes an 8-bit special-function register access from the core
package spi_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_CONTROL    = 8'h9a;
  localparam logic [7:0] ADDR_DATA       = 8'h9b;
  localparam logic [7:0] ADDR_RX_CTRL    = 8'h9c;
  localparam logic [7:0] ADDR_TX_CTRL    = 8'h9d;
  localparam logic [7:0] ADDR_RING_START = 8'h9e;
  localparam logic [7:0] ADDR_RING_END   = 8'h9f;

  // ==========================================================
  // field positions
  localparam int CTL_RATE_LSB  = 5;
  localparam int CTL_RING      = 4;
  localparam int CTL_LSB_FIRST = 3;
  localparam int CTL_MASTER    = 2;
  localparam int CTL_PHASE     = 1;
  localparam int CTL_POLARITY  = 0;
  localparam int FLUSH_BIT     = 7;
  localparam int TX_CLK_EN     = 5;
  localparam int TX_OUTPUT_CHANGE_DELAY    = 4;
  localparam int TX_OUTPUT_DRIVE_ENABLE     = 3;
  localparam int THR_LSB       = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [2:0] THR_RESET     = 3'h0;
  localparam logic [6:0] RING_RESET    = 7'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;

  // ==========================================================
  // auxiliary interrupt index codes and timing
  localparam logic [3:0] AUX_NONE  = 4'h0;
  localparam logic [3:0] AUX_RX    = 4'h3;
  localparam logic [3:0] AUX_TX    = 4'h4;
  localparam logic [3:0] EDGE_LAST = 4'hf;
  localparam int         BUF_DEPTH = 4;

  typedef enum logic {SH_IDLE, SH_BUSY} shift_state_t;

endpackage

// ### logic/byte_fifo.sv
// small synchronous fifo for the double-buffered data path
// assumes push and pop are qualified by ready and valid in the same cycle
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  localparam int AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  localparam int CW   = $clog2(DEPTH + 1)
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [CW-1:0]    count
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    wr_nxt;
  logic [AW-1:0]    rd_r;
  logic [AW-1:0]    rd_nxt;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready  = (cnt_r != CW'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign count     = cnt_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================
  // next state
  always_comb
  begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (flush)
    begin
      wr_nxt  = '0;
      rd_nxt  = '0;
      cnt_nxt = '0;
    end
    else
    begin
      if (push)
      begin
        mem_nxt[wr_r] = in_data;
        wr_nxt        = ptr_next(wr_r);
      end
      if (pop)
        rd_nxt = ptr_next(rd_r);
      if (push && !pop)
        cnt_nxt = CW'(cnt_r + 1'b1);
      else if (pop && !push)
        cnt_nxt = CW'(cnt_r - 1'b1);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mem_r <= '{default: '0};
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

`default_nettype wire

// ### logic/spi_master_slave_fifo.sv
// serial peripheral port, master or slave, with double buffers or a ring buffer
// assumes a one-cycle register write or read strobe from the core and
// link pins already synchronous to clock
`timescale 1ns/10ps
`default_nettype none

// Operation
// - changing control write resets port, counters, pointers
// - external select decides whether port answers
// - master divides clock by two to 256
// - buffer mode picks double buffers or ring
// - order bit picks msb or lsb first
// - phase bit picks data before or at edge
// - polarity bit picks clock idle level
// - data address writes transmit, reads receive
// - receive count readable, zero to 127
// - receive flush one empties receive buffer
// - receive interrupt when count reaches threshold
// - transmit count readable, zero to 127
// - transmit flush drops pending bytes, reads zero
// - clock driver enable gates master clock output
// - data drive enable, immediate or after byte
// - transmit interrupt when count at or under threshold
// - start address write clears both counters
// - transmit pointer stops short of receive pointer
// - receive pointer advances while count nonzero
// - auxiliary index reports receive 3, transmit 4
module spi_master_slave_fifo
  import spi_pkg::*;
#(
  parameter int RING_SIZE = 128,
  parameter int DEPTH     = spi_pkg::BUF_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       spi_select,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       ss_n_in,
  input  wire logic       data_in,
  output logic            data_out,
  output logic            data_oe,
  output logic            rx_irq,
  output logic            tx_irq,
  output logic      [3:0] aux_index
);

  import spi_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // ==========================================================
  // declarations
  logic [7:0]   ctrl_r, ctrl_nxt;
  logic [2:0]   rx_thr_r, rx_thr_nxt;
  logic [2:0]   tx_thr_r, tx_thr_nxt;
  logic         clk_en_r, clk_en_nxt;
  logic         output_drive_enable_r, output_drive_enable_nxt;
  logic         drive_r, drive_nxt;
  logic         pend_r, pend_nxt;
  logic [6:0]   start_r, start_nxt;
  logic [6:0]   end_r, end_nxt;
  logic [6:0]   tx_ptr_r, tx_ptr_nxt;
  logic [6:0]   out_ptr_r, out_ptr_nxt;
  logic [6:0]   rx_ptr_r, rx_ptr_nxt;
  logic [7:0]   tx_cnt_r, tx_cnt_nxt;
  logic [7:0]   rx_cnt_r, rx_cnt_nxt;
  logic [7:0]   mem_r [RING_SIZE];
  logic [7:0]   mem_nxt [RING_SIZE];
  logic [7:0]   rdata_r, rdata_nxt;

  shift_state_t st_r, st_nxt;
  logic [3:0]   edge_cnt_r, edge_cnt_nxt;
  logic [7:0]   tx_sh_r, tx_sh_nxt;
  logic [7:0]   rx_sh_r, rx_sh_nxt;
  logic         sck_r, sck_nxt;
  logic         sck_prev_r, sck_prev_nxt;
  logic [7:0]   div_cnt_r, div_cnt_nxt;
  logic         had_src_r, had_src_nxt;

  logic         wr, rd, ctl_reset, ring, master, clock_phase_bit, clock_polarity_bit, lsb;
  logic         wr_data, rd_data, tx_flush, rx_flush;
  logic         src_valid, start_xfer, tick, sck_edge, lead, sample, shift, done;
  logic [7:0]   src_byte, rx_shifted, rx_byte, thr_rx, thr_tx, rx_count, tx_count;
  logic         txf_in_ready, txf_out_valid, rxf_in_ready, rxf_out_valid;
  logic [7:0]   txf_out_data, rxf_out_data;
  logic [CW-1:0] txf_count, rxf_count;
  logic         txf_pop, rxf_push, rxf_pop, fifo_flush_tx, fifo_flush_rx;

  // next ring address, wrapping from the end address back to the start
  function automatic logic [6:0] ring_next(input logic [6:0] p, input logic [6:0] s, input logic [6:0] e);
    ring_next = (p == e) ? s : 7'(p + 7'h01);
  endfunction

  // ==========================================================
  // decode
  assign wr        = sfr_wr && spi_select;
  assign rd        = sfr_rd && spi_select;
  assign ctl_reset = wr && (sfr_addr == ADDR_CONTROL) && (sfr_wdata != ctrl_r);
  assign ring      = ctrl_r[CTL_RING];
  assign master    = ctrl_r[CTL_MASTER];
  assign clock_phase_bit      = ctrl_r[CTL_PHASE];
  assign clock_polarity_bit      = ctrl_r[CTL_POLARITY];
  assign lsb       = ctrl_r[CTL_LSB_FIRST];
  assign wr_data   = wr && (sfr_addr == ADDR_DATA);
  assign rd_data   = rd && (sfr_addr == ADDR_DATA);
  assign tx_flush  = wr && (sfr_addr == ADDR_TX_CTRL) && sfr_wdata[FLUSH_BIT];
  assign rx_flush  = wr && (sfr_addr == ADDR_RX_CTRL) && sfr_wdata[FLUSH_BIT];

  assign src_valid = ring ? (tx_cnt_r != 8'h00) : txf_out_valid;
  assign src_byte  = ring ? mem_r[out_ptr_r] : txf_out_data;
  assign rx_count  = ring ? rx_cnt_r : 8'(rxf_count);
  assign tx_count  = ring ? tx_cnt_r : 8'(txf_count);

  // ==========================================================
  // double buffers
  assign fifo_flush_tx = ctl_reset || (tx_flush && !ring);
  assign fifo_flush_rx = ctl_reset || (rx_flush && !ring);
  assign txf_pop       = start_xfer && !ring;
  assign rxf_push      = done && !ring;
  assign rxf_pop       = rd_data && !ring;

  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) tx_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (fifo_flush_tx),
    .in_valid  (wr_data && !ring),
    .in_ready  (txf_in_ready),
    .in_data   (sfr_wdata),
    .out_valid (txf_out_valid),
    .out_ready (txf_pop),
    .out_data  (txf_out_data),
    .count     (txf_count)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rx_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .flush     (fifo_flush_rx),
    .in_valid  (rxf_push),
    .in_ready  (rxf_in_ready),
    .in_data   (rx_byte),
    .out_valid (rxf_out_valid),
    .out_ready (rxf_pop),
    .out_data  (rxf_out_data),
    .count     (rxf_count)
  );

  // ==========================================================
  // shift engine
  assign tick       = master && (st_r == SH_BUSY) &&
                      (div_cnt_r == 8'((8'h01 << ctrl_r[CTL_RATE_LSB +: 3]) - 8'h01));
  assign sck_edge   = master ? tick : (!ss_n_in && (sck_in != sck_prev_r) && (st_r == SH_BUSY));
  assign lead       = master ? (sck_r == clock_polarity_bit) : (sck_in != clock_polarity_bit);
  assign sample     = sck_edge && (lead ^ clock_phase_bit);
  assign shift      = sck_edge && !(lead ^ clock_phase_bit) && (edge_cnt_r != 4'h0);
  assign done       = sck_edge && (edge_cnt_r == EDGE_LAST);
  assign rx_shifted = lsb ? {data_in, rx_sh_r[7:1]} : {rx_sh_r[6:0], data_in};
  assign rx_byte    = sample ? rx_shifted : rx_sh_r;
  assign start_xfer = (st_r == SH_IDLE) && spi_select && !ctl_reset &&
                      (master ? src_valid : !ss_n_in);

  always_comb
  begin
    st_nxt       = st_r;
    edge_cnt_nxt = edge_cnt_r;
    tx_sh_nxt    = tx_sh_r;
    rx_sh_nxt    = rx_sh_r;
    sck_nxt      = sck_r;
    sck_prev_nxt = sck_in;
    div_cnt_nxt  = div_cnt_r;
    had_src_nxt  = had_src_r;
    unique case (st_r)
      SH_IDLE:
      begin
        sck_nxt      = clock_polarity_bit;
        div_cnt_nxt  = 8'h00;
        edge_cnt_nxt = 4'h0;
        if (start_xfer)
        begin
          st_nxt      = SH_BUSY;
          tx_sh_nxt   = src_valid ? src_byte : 8'h00;
          had_src_nxt = src_valid;
        end
      end
      SH_BUSY:
      begin
        div_cnt_nxt = tick ? 8'h00 : 8'(div_cnt_r + 8'h01);
        if (tick)
          sck_nxt = !sck_r;
        if (sample)
          rx_sh_nxt = rx_shifted;
        if (shift)
          tx_sh_nxt = lsb ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
        if (sck_edge)
          edge_cnt_nxt = 4'(edge_cnt_r + 4'h1);
        if (done || (!master && ss_n_in))
        begin
          st_nxt  = SH_IDLE;
          sck_nxt = clock_polarity_bit;
        end
      end
    endcase
    if (ctl_reset || !spi_select)
    begin
      st_nxt  = SH_IDLE;
      sck_nxt = clock_polarity_bit;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_r       <= SH_IDLE;
      edge_cnt_r <= 4'h0;
      tx_sh_r    <= DATA_RESET;
      rx_sh_r    <= DATA_RESET;
      sck_r      <= 1'b0;
      sck_prev_r <= 1'b0;
      div_cnt_r  <= 8'h00;
      had_src_r  <= 1'b0;
    end
    else
    begin
      st_r       <= st_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      tx_sh_r    <= tx_sh_nxt;
      rx_sh_r    <= rx_sh_nxt;
      sck_r      <= sck_nxt;
      sck_prev_r <= sck_prev_nxt;
      div_cnt_r  <= div_cnt_nxt;
      had_src_r  <= had_src_nxt;
    end
  end

  // ==========================================================
  // registers, ring pointers and counters
  always_comb
  begin
    ctrl_nxt    = ctrl_r;
    rx_thr_nxt  = rx_thr_r;
    tx_thr_nxt  = tx_thr_r;
    clk_en_nxt  = clk_en_r;
    output_drive_enable_nxt  = output_drive_enable_r;
    drive_nxt   = drive_r;
    pend_nxt    = pend_r;
    start_nxt   = start_r;
    end_nxt     = end_r;
    tx_ptr_nxt  = tx_ptr_r;
    out_ptr_nxt = out_ptr_r;
    rx_ptr_nxt  = rx_ptr_r;
    tx_cnt_nxt  = tx_cnt_r;
    rx_cnt_nxt  = rx_cnt_r;
    mem_nxt     = mem_r;
    rdata_nxt   = 8'h00;
    // finished byte overwrites its slot with the received byte
    if (ring && done && had_src_r)
    begin
      mem_nxt[out_ptr_r] = rx_byte;
      out_ptr_nxt        = ring_next(out_ptr_r, start_r, end_r);
      tx_cnt_nxt         = 8'(tx_cnt_nxt - 8'h01);
      rx_cnt_nxt         = 8'(rx_cnt_nxt + 8'h01);
    end
    if (done && pend_r)
    begin
      drive_nxt = output_drive_enable_r;
      pend_nxt  = 1'b0;
    end
    if (ring && wr_data && (ring_next(tx_ptr_r, start_r, end_r) != rx_ptr_r))
    begin
      mem_nxt[tx_ptr_r] = sfr_wdata;
      tx_ptr_nxt        = ring_next(tx_ptr_r, start_r, end_r);
      tx_cnt_nxt        = 8'(tx_cnt_nxt + 8'h01);
    end
    if (ring && rd_data && (rx_cnt_r != 8'h00))
    begin
      rx_ptr_nxt = ring_next(rx_ptr_r, start_r, end_r);
      rx_cnt_nxt = 8'(rx_cnt_nxt - 8'h01);
    end
    if (wr && (sfr_addr == ADDR_RX_CTRL))
    begin
      rx_thr_nxt = sfr_wdata[THR_LSB +: 3];
      if (sfr_wdata[FLUSH_BIT] && ring)
      begin
        rx_ptr_nxt = out_ptr_nxt;
        rx_cnt_nxt = COUNT_RESET;
      end
    end
    if (wr && (sfr_addr == ADDR_TX_CTRL))
    begin
      tx_thr_nxt = sfr_wdata[THR_LSB +: 3];
      clk_en_nxt = sfr_wdata[TX_CLK_EN];
      output_drive_enable_nxt = sfr_wdata[TX_OUTPUT_DRIVE_ENABLE];
      if (!sfr_wdata[TX_OUTPUT_CHANGE_DELAY] || (st_r == SH_IDLE))
      begin
        drive_nxt = sfr_wdata[TX_OUTPUT_DRIVE_ENABLE];
        pend_nxt  = 1'b0;
      end
      else
        pend_nxt = 1'b1;
      if (sfr_wdata[FLUSH_BIT] && ring)
      begin
        tx_ptr_nxt = out_ptr_nxt;
        tx_cnt_nxt = COUNT_RESET;
      end
    end
    if (wr && (sfr_addr == ADDR_RING_END))
      end_nxt = sfr_wdata[6:0];
    if (wr && (sfr_addr == ADDR_RING_START))
    begin
      start_nxt   = sfr_wdata[6:0];
      tx_ptr_nxt  = sfr_wdata[6:0];
      out_ptr_nxt = sfr_wdata[6:0];
      rx_ptr_nxt  = sfr_wdata[6:0];
      tx_cnt_nxt  = COUNT_RESET;
      rx_cnt_nxt  = COUNT_RESET;
    end
    if (ctl_reset)
    begin
      ctrl_nxt    = sfr_wdata;
      tx_ptr_nxt  = start_r;
      out_ptr_nxt = start_r;
      rx_ptr_nxt  = start_r;
      tx_cnt_nxt  = COUNT_RESET;
      rx_cnt_nxt  = COUNT_RESET;
      pend_nxt    = 1'b0;
      drive_nxt   = output_drive_enable_r;
    end
    if (rd)
    begin
      unique case (sfr_addr)
        ADDR_CONTROL:    rdata_nxt = ctrl_r;
        ADDR_DATA:       rdata_nxt = ring ? mem_r[rx_ptr_r] : rxf_out_data;
        ADDR_RX_CTRL:    rdata_nxt = rx_count;
        ADDR_TX_CTRL:    rdata_nxt = tx_count;
        ADDR_RING_START: rdata_nxt = {1'b0, tx_ptr_r};
        ADDR_RING_END:   rdata_nxt = {1'b0, rx_ptr_r};
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    mem_r <= mem_nxt;
    if (!rst_n)
    begin
      ctrl_r    <= CONTROL_RESET;
      rx_thr_r  <= THR_RESET;
      tx_thr_r  <= THR_RESET;
      clk_en_r  <= 1'b0;
      output_drive_enable_r  <= 1'b0;
      drive_r   <= 1'b0;
      pend_r    <= 1'b0;
      start_r   <= RING_RESET;
      end_r     <= RING_RESET;
      tx_ptr_r  <= RING_RESET;
      out_ptr_r <= RING_RESET;
      rx_ptr_r  <= RING_RESET;
      tx_cnt_r  <= COUNT_RESET;
      rx_cnt_r  <= COUNT_RESET;
      rdata_r   <= DATA_RESET;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      rx_thr_r  <= rx_thr_nxt;
      tx_thr_r  <= tx_thr_nxt;
      clk_en_r  <= clk_en_nxt;
      output_drive_enable_r  <= output_drive_enable_nxt;
      drive_r   <= drive_nxt;
      pend_r    <= pend_nxt;
      start_r   <= start_nxt;
      end_r     <= end_nxt;
      tx_ptr_r  <= tx_ptr_nxt;
      out_ptr_r <= out_ptr_nxt;
      rx_ptr_r  <= rx_ptr_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign thr_rx    = 8'(8'h01 << rx_thr_r);
  assign thr_tx    = 8'(8'h01 << tx_thr_r);
  assign rx_irq    = spi_select && (rx_count >= thr_rx);
  assign tx_irq    = spi_select && (tx_count <= thr_tx);
  assign aux_index = rx_irq ? AUX_RX : (tx_irq ? AUX_TX : AUX_NONE);
  assign sfr_rdata = rdata_r;
  assign sck_out   = sck_r;
  assign sck_oe    = spi_select && master && clk_en_r;
  assign data_out  = lsb ? tx_sh_r[0] : tx_sh_r[7];
  assign data_oe   = spi_select && drive_r && (master || !ss_n_in);

endmodule

`default_nettype wire

// ### dv/spi_asserts.sv
// concurrent checks on the serial port pins and register strobes
// assumes it is bound to spi_master_slave_fifo and sees its ports only
`timescale 1ns/10ps
`default_nettype none

module spi_asserts (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       spi_select,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       data_oe,
  input wire logic       rx_irq,
  input wire logic       tx_irq,
  input wire logic [3:0] aux_index
);
  import spi_pkg::*;

  // ==========================================================
  // shadow of the written settings
  logic [7:0] ctl_r, ctl_nxt, txc_r, txc_nxt;
  logic [8:0] gap_r, gap_nxt;
  logic       sck_r, armed_r, armed_nxt, wr_ctl, wr_txc, tog;

  always_comb
  begin
    wr_ctl    = sfr_wr && spi_select && sfr_addr == ADDR_CONTROL && sfr_wdata != ctl_r;
    wr_txc    = sfr_wr && spi_select && sfr_addr == ADDR_TX_CTRL;
    tog       = sck_out != sck_r;
    ctl_nxt   = wr_ctl ? sfr_wdata : ctl_r;
    txc_nxt   = wr_txc ? sfr_wdata : txc_r;
    gap_nxt   = tog ? 9'h001 : (gap_r == 9'h1ff ? gap_r : gap_r + 9'h001);
    armed_nxt = wr_ctl ? 1'b0 : (tog ? 1'b1 : armed_r);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctl_r   <= 8'h00;
      txc_r   <= 8'h00;
      gap_r   <= 9'h000;
      sck_r   <= 1'b0;
      armed_r <= 1'b0;
    end
    else
    begin
      ctl_r   <= ctl_nxt;
      txc_r   <= txc_nxt;
      gap_r   <= gap_nxt;
      sck_r   <= sck_out;
      armed_r <= armed_nxt;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_rdata_idle;
    !$past(sfr_rd) |-> sfr_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
  property p_aux_rx;
    rx_irq |-> aux_index == AUX_RX;
  endproperty
  a_aux_rx: assert property (p_aux_rx) else $error("aux index not receive code");
  property p_aux_tx;
    !rx_irq |-> aux_index == (tx_irq ? AUX_TX : AUX_NONE);
  endproperty
  a_aux_tx: assert property (p_aux_tx) else $error("aux index not transmit or none");
  property p_sck_oe;
    sck_oe == (spi_select && ctl_r[CTL_MASTER] && txc_r[TX_CLK_EN]);
  endproperty
  a_sck_oe: assert property (p_sck_oe) else $error("clock driver enable wrong");
  property p_sck_rest;
    wr_ctl |=> ##[0:1] sck_out == ctl_r[CTL_POLARITY];
  endproperty
  a_sck_rest: assert property (p_sck_rest) else $error("clock not at rest after control change");
  property p_half;
    tog && armed_r && ctl_r[CTL_MASTER] |-> gap_r >= (9'h001 << ctl_r[7:5]);
  endproperty
  a_half: assert property (p_half) else $error("clock half period too short");
  property p_deselect;
    !spi_select |-> !rx_irq && !tx_irq && !sck_oe && !data_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("port active while deselected");
  property p_drive_now;
    wr_txc && !sfr_wdata[TX_OUTPUT_CHANGE_DELAY] && ctl_r[CTL_MASTER] |=> data_oe == txc_r[TX_OUTPUT_DRIVE_ENABLE];
  endproperty
  a_drive_now: assert property (p_drive_now) else $error("data drive not immediate");
  property p_start_clear;
    sfr_wr && spi_select && sfr_addr == ADDR_RING_START && ctl_r[CTL_RING] |=> tx_irq && !rx_irq;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start write left counts");
endmodule

bind spi_master_slave_fifo spi_asserts u_asserts (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .spi_select(spi_select),
  .sck_out(sck_out), .sck_oe(sck_oe), .data_oe(data_oe), .rx_irq(rx_irq), .tx_irq(tx_irq),
  .aux_index(aux_index));

`default_nettype wire

// ### dv/spi_slave_model.sv
// external serial slave: answers a loaded byte, captures the byte it gets
// assumes the master clock rests at polarity outside frames
`timescale 1ns/10ps
`default_nettype none

module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       pol,
  input  wire logic       pha,
  input  wire logic       lsb,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte,
  output logic            done
);
  int k;

  function automatic int pos(input int i);
    return lsb ? i : 7 - i;
  endfunction

  initial
  begin
    k = 0;
    miso = 1'b0;
    rx_byte = 8'h00;
    done = 1'b0;
  end

  // with phase set the line shows the inverse of its last level, else the first bit
  always @(posedge load)
  begin
    k = 0;
    done = 1'b0;
    miso = pha ? ~miso : tx_byte[pos(0)];
  end

  always @(sck)
  begin
    if (sck != pol)
    begin
      if (pha)
        miso = tx_byte[pos(k)];
      else
        rx_byte[pos(k)] = mosi;
    end
    else
    begin
      if (pha)
        rx_byte[pos(k)] = mosi;
      k = k + 1;
      if (k == 8)
      begin
        k = 0;
        done = 1'b1;
        miso = pha ? ~miso : tx_byte[pos(0)];
      end
      else if (!pha)
        miso = tx_byte[pos(k)];
    end
  end
endmodule

`default_nettype wire

// ### dv/tb_top.sv
// bench: register tasks and master transfers against the slave model
// assumes the port is reached through its register strobes only
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import spi_pkg::*;
  logic       clock, rst_n, sfr_wr, sfr_rd, spi_select, load, sck_q;
  logic       sck_out, sck_oe, data_out, data_oe, rx_irq, tx_irq, miso, done;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, slv_tx, slv_rx, c, v;
  logic [3:0] aux_index;
  int         mismatches, samples_checked, gap, half_seen, w;

  spi_master_slave_fifo u_dut (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .spi_select(spi_select), .sck_in(1'b0),
    .sck_out(sck_out), .sck_oe(sck_oe), .ss_n_in(1'b1), .data_in(miso), .data_out(data_out),
    .data_oe(data_oe), .rx_irq(rx_irq), .tx_irq(tx_irq), .aux_index(aux_index));
  spi_slave_model u_slave (.sck(sck_out), .mosi(data_out), .pol(c[0]), .pha(c[1]), .lsb(c[3]),
    .load(load), .tx_byte(slv_tx), .miso(miso), .rx_byte(slv_rx), .done(done));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // cycles between clock pin toggles
  always @(posedge clock)
  begin
    gap = gap + 1;
    if (sck_out !== sck_q)
    begin
      half_seen = gap;
      gap = 0;
    end
    sck_q = sck_out;
  end

  // ==========================================================
  // tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    v = sfr_rdata;
    sfr_rd = 1'b0;
    chk(what, v, exp);
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    mismatches++;
    summarize();
  end

  // ==========================================================
  // tests
  initial
  begin
    {rst_n, sfr_wr, sfr_rd, load, sck_q, sfr_addr, sfr_wdata, slv_tx, c} = '0;
    {mismatches, samples_checked, gap, half_seen, w} = '0;
    spi_select = 1'b1;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    for (int a = 8'h9a; a <= 8'h9f; a++)
      rchk(8'(a), 8'h00, "reset value");
    rchk(8'h80, 8'h00, "unmapped");
    chk("irq aux", {aux_index, 1'b0, sck_oe, rx_irq, tx_irq}, {AUX_TX, 4'h1});
    spi_select = 1'b0;
    wr(ADDR_CONTROL, 8'h04);
    rchk(ADDR_CONTROL, 8'h00, "deselected read");
    chk("deselected irq", {7'h0, tx_irq}, 8'h00);
    spi_select = 1'b1;
    rchk(ADDR_CONTROL, 8'h00, "write ignored");
    $display("test reset and select done");
    for (int i = 0; i < 8; i++)
    begin
      c = {i[2:0], 1'b0, i[2], 1'b1, i[1], i[0]};
      wr(ADDR_CONTROL, c);
      wr(ADDR_TX_CTRL, 8'h28);
      chk("sck rest", {7'h0, sck_out}, {7'h0, c[0]});
      chk("drivers", {6'h0, sck_oe, data_oe}, 8'h03);
      slv_tx = 8'h3a ^ c;
      load = 1'b1;
      #1 load = 1'b0;
      wr(ADDR_DATA, 8'hb4 ^ c);
      for (w = 0; w < 5000 && done !== 1'b1; w++)
        @(negedge clock);
      repeat (3) @(negedge clock);
      chk("slave done", {7'h0, done}, 8'h01);
      chk("slave rx", slv_rx, 8'hb4 ^ c);
      chk("half period", 8'(half_seen), 8'(1 << i));
      rchk(ADDR_RX_CTRL, 8'h01, "rx count");
      chk("rx irq", {aux_index, 3'h0, rx_irq}, {AUX_RX, 4'h1});
      wr(ADDR_RX_CTRL, 8'h01);
      chk("rx irq thr", {aux_index, 3'h0, rx_irq}, {AUX_TX, 4'h0});
      wr(ADDR_RX_CTRL, 8'h00);
      if (i[0])
        rchk(ADDR_DATA, 8'h3a ^ c, "rx data");
      else
        wr(ADDR_RX_CTRL, 8'h80);
      rchk(ADDR_RX_CTRL, 8'h00, "rx empty");
      $display("test transfer %0d done", i);
    end
    wr(ADDR_TX_CTRL, 8'h08);
    chk("clock driver off", {7'h0, sck_oe}, 8'h00);
    wr(ADDR_TX_CTRL, 8'h00);
    chk("data tristate", {7'h0, data_oe}, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    for (int i = 0; i < 5; i++)
      wr(ADDR_DATA, 8'(i));
    rchk(ADDR_TX_CTRL, 8'h04, "tx full");
    wr(ADDR_TX_CTRL, 8'h02);
    chk("tx irq le 4", {7'h0, tx_irq}, 8'h01);
    wr(ADDR_TX_CTRL, 8'h01);
    chk("tx irq le 2", {7'h0, tx_irq}, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_TX_CTRL, 8'h04, "same control");
    wr(ADDR_TX_CTRL, 8'h81);
    rchk(ADDR_TX_CTRL, 8'h00, "tx flushed");
    wr(ADDR_DATA, 8'h5a);
    wr(ADDR_CONTROL, 8'h01);
    rchk(ADDR_TX_CTRL, 8'h00, "control change");
    $display("test double buffer done");
    wr(ADDR_CONTROL, 8'h10);
    wr(ADDR_RING_START, 8'h10);
    wr(ADDR_RING_END, 8'h13);
    rchk(ADDR_RING_START, 8'h10, "tx pointer");
    for (int i = 0; i < 4; i++)
      wr(ADDR_DATA, 8'hc0 + 8'(i));
    rchk(ADDR_TX_CTRL, 8'h03, "ring count");
    rchk(ADDR_RING_START, 8'h13, "tx pointer stop");
    rchk(ADDR_RING_END, 8'h10, "rx pointer");
    wr(ADDR_RING_START, 8'h10);
    rchk(ADDR_TX_CTRL, 8'h00, "counts cleared");
    $display("test ring done");
    summarize();
  end
endmodule

`default_nettype wire
